// [core/duc_channel.sv]
/*
 * Transmit and receive engine of one asynchronous serial channel.
 * Assumes baud ticks (16x or 1x) and crystal edges as same-clock
 * pulses; serial pins and flow inputs are asynchronous.
 */
`timescale 1ns/1ps

// Overview of operation
// - Enabling transmitter sets tx-ready and tx-empty flags.
// - Loading clears tx-empty; it sets again when FIFO and shifter drain.
// - Frame: start, data LSB first, optional parity, stops; idle high.
// - Disable refuses writes, drops tx interrupt, drains queue first.
// - Transmitter reset halts at once and empties the FIFO.
// - Start-break holds output low until stop-break or reset.
// - CTS gating checked at each character start; mid-char rise ignored.
// - Mode-two bit 5 lets transmitter drive RTS as end of message.
// - Start bit recheck at mid-bit; high sample restarts search.
// - Sample bits at centre, push character, set receive-ready.
// - Short characters store zeros in unused upper bits.
// - Nonzero char without stop, low half bit later: new start.
// - Full-low char loads zero with break; ends after 2 high edges.
// - Receive FIFO 8 or 16 deep with ready and full flags.
// - Data read pops entry and status; status read never pops.
// - Entry holds parity, framing, break; overrun kept separately.
// - Character mode shows head; block mode ORs heads until reset.
// - Full FIFO: char waits; newcomer's start sets overrun, its end overwrites the waiting char.
// - Flow control raises RTS on start with FIFO full; lowers on room.
// - Receiver disable drops partial char, FIFO stays readable.
// - Receiver reset clears shifter, ready, status, pointers, pins.
// - Disabled receiver keeps flags and watchdog active.
// - Watchdog expires after 64 bit times; restarts on load or read.
module duc_channel #(
    parameter int DEPTH = duc_pkg::DUC_DEPTH_LARGE
) (
    // Clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    // Timing
    input  wire logic               i_tx_tick,
    input  wire logic               i_rx_tick,
    input  wire logic               i_rx_x16,
    input  wire logic               i_xtal_edge,
    // Control
    input  wire logic               i_tx_en,
    input  wire logic               i_rx_en,
    input  wire duc_pkg::duc_cmd_t  i_cmd,
    input  wire logic [7:0]         i_mode_register_two,
    input  wire duc_pkg::duc_fmt_t  i_fmt,
    input  wire logic               i_block_err,
    input  wire logic               i_rx_flow_en,
    input  wire logic               i_depth8,
    input  wire logic               i_wdog_en,
    // Host data
    input  wire logic               i_tx_wr,
    input  wire logic [7:0]         i_tx_data,
    input  wire logic               i_rx_rd,
    // Host status
    output logic [7:0]              o_rx_data,
    output duc_pkg::duc_rx_stat_t   o_rx_stat,
    output logic                    o_tx_ready_flag,
    output logic                    o_tx_empty_flag,
    output logic                    o_tx_irq,
    output logic                    o_rx_ready_flag,
    output logic                    o_rx_fifo_full_flag,
    output logic                    o_wdog_expired,
    // Line
    input  wire logic               i_rxd,
    input  wire logic               i_cts_low,
    output logic                    o_txd,
    output logic                    o_request_to_send_low
);
    import duc_pkg::*;

    initial
    begin
        if (DEPTH != DUC_DEPTH_LARGE)
            $error("duc_channel: DEPTH must be 16");
    end

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [1:0] rxd_s_q;
    logic [1:0] cts_s_q;
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            rxd_s_q <= 2'h3;
            cts_s_q <= 2'h3;
        end
        else
        begin
            rxd_s_q <= {rxd_s_q[0], i_rxd};
            cts_s_q <= {cts_s_q[0], i_cts_low};
        end
    end
    wire rxd = rxd_s_q[1];
    wire cts_high = cts_s_q[1];

    // ------------------------------------------------------------
    // Common helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] data_bits(input logic [1:0] sel);
        data_bits = 4'(5 + sel);
    endfunction
    wire [3:0] nbits = data_bits(i_fmt.bits_sel);
    wire [3:0] ticks_per_bit = i_rx_x16 ? 4'hF : 4'h0;

    // ------------------------------------------------------------
    // Transmit FIFO
    // ------------------------------------------------------------
    logic       tx_en_q;
    logic       tx_busy_q;
    logic       txf_ready;
    logic       txf_valid;
    logic [7:0] txf_data;
    logic       txf_full;
    logic       tx_take;
    wire        tx_reset = (i_cmd == DUC_CMD_TX_RESET);
    wire        tx_push  = i_tx_wr && i_tx_en;

    duc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txf (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_flush (tx_reset),
        .i_half  (i_depth8),
        .i_valid (tx_push),
        .o_ready (txf_ready),
        .i_data  (i_tx_data),
        .o_valid (txf_valid),
        .i_ready (tx_take),
        .o_data  (txf_data),
        .o_full  (txf_full)
    );

    // ------------------------------------------------------------
    // Transmit serialiser
    // ------------------------------------------------------------
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR,
                              TX_STOP} tx_st_t;
    tx_st_t     tx_st_q;
    logic [7:0] tx_sh_q;
    logic [3:0] tx_cnt_q;
    logic [3:0] tx_tk_q;
    logic [1:0] tx_stops_q;
    logic       tx_par_q;
    logic       brk_q;
    wire        cts_ok = !i_mode_register_two[DUC_MR2_CTS_BIT] || !cts_high;
    wire        bit_end = i_tx_tick && (tx_tk_q == ticks_per_bit);
    // Take only on a tick so the start bit lasts a full bit time
    assign tx_take = (tx_st_q == TX_IDLE) && txf_valid && cts_ok
                     && i_tx_tick && !tx_reset;

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || tx_reset)
        begin
            tx_st_q    <= TX_IDLE;
            tx_sh_q    <= 8'h00;
            tx_cnt_q   <= 4'h0;
            tx_tk_q    <= 4'h0;
            tx_stops_q <= 2'h0;
            tx_par_q   <= 1'b0;
        end
        else if (tx_take)
        begin
            tx_st_q    <= TX_START;
            tx_sh_q    <= txf_data;
            tx_par_q   <= i_fmt.par_odd;
            tx_tk_q    <= 4'h0;
            tx_cnt_q   <= 4'h0;
            tx_stops_q <= i_fmt.two_stop ? 2'h2 : 2'h1;
        end
        else if (i_tx_tick)
        begin
            tx_tk_q <= bit_end ? 4'h0 : tx_tk_q + 4'h1;
            if (bit_end)
            begin
                unique case (tx_st_q)
                    TX_IDLE:  tx_st_q <= TX_IDLE;
                    TX_START: tx_st_q <= TX_DATA;
                    TX_DATA:
                    begin
                        tx_par_q <= tx_par_q ^ tx_sh_q[0];
                        tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                        tx_cnt_q <= tx_cnt_q + 4'h1;
                        if (tx_cnt_q == nbits - 4'h1)
                            tx_st_q <= i_fmt.par_en ? TX_PAR : TX_STOP;
                    end
                    TX_PAR:   tx_st_q <= TX_STOP;
                    TX_STOP:
                    begin
                        tx_stops_q <= tx_stops_q - 2'h1;
                        if (tx_stops_q == 2'h1)
                            tx_st_q <= TX_IDLE;
                    end
                endcase
            end
        end
    end

    wire tx_line = (tx_st_q == TX_START) ? 1'b0 :
                   (tx_st_q == TX_DATA)  ? tx_sh_q[0] :
                   (tx_st_q == TX_PAR)   ? tx_par_q : 1'b1;
    wire tx_idle_all = (tx_st_q == TX_IDLE) && !txf_valid;

    // ------------------------------------------------------------
    // Transmit flags, break, RTS
    // ------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            tx_en_q         <= 1'b0;
            brk_q           <= 1'b0;
            o_txd           <= 1'b1;
            o_tx_ready_flag <= 1'b0;
            o_tx_empty_flag <= 1'b0;
            o_tx_irq        <= 1'b0;
            tx_busy_q       <= 1'b0;
        end
        else
        begin
            tx_en_q <= i_tx_en;
            if (tx_reset || i_cmd == DUC_CMD_BRK_STOP)
                brk_q <= 1'b0;
            else if (i_cmd == DUC_CMD_BRK_START)
                brk_q <= 1'b1;
            o_txd <= brk_q ? 1'b0 : tx_line;
            tx_busy_q <= !tx_idle_all || tx_push;
            o_tx_ready_flag <= i_tx_en && (txf_ready || tx_reset);
            if (i_tx_en && !tx_en_q)
                o_tx_empty_flag <= 1'b1;
            else if (tx_push)
                o_tx_empty_flag <= 1'b0;
            else if (tx_idle_all)
                o_tx_empty_flag <= 1'b1;
            o_tx_irq <= i_tx_en && txf_ready;
        end
    end

    // ------------------------------------------------------------
    // Receive FIFO
    // ------------------------------------------------------------
    duc_rx_entry_t rx_new_q;
    duc_rx_entry_t rxf_head;
    logic          rx_hold_q;
    logic          rxf_ready;
    logic          rxf_valid;
    logic          rxf_full;
    wire           rx_reset = (i_cmd == DUC_CMD_RX_RESET);
    wire           rx_pop = i_rx_rd && rxf_valid;

    duc_fifo #(.WIDTH($bits(duc_rx_entry_t)), .DEPTH(DEPTH)) u_rxf (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_flush (rx_reset),
        .i_half  (i_depth8),
        .i_valid (rx_hold_q),
        .o_ready (rxf_ready),
        .i_data  (rx_new_q),
        .o_valid (rxf_valid),
        .i_ready (i_rx_rd),
        .o_data  (rxf_head),
        .o_full  (rxf_full)
    );
    wire rx_load = rx_hold_q && rxf_ready;

    // ------------------------------------------------------------
    // Receive deserialiser
    // ------------------------------------------------------------
    typedef enum logic [2:0] {RX_HUNT, RX_START, RX_DATA, RX_PAR,
                              RX_STOP, RX_REFRAME, RX_BREAK} rx_st_t;
    rx_st_t     rx_st_q;
    logic [7:0] rx_sh_q;
    logic [3:0] rx_cnt_q;
    logic [3:0] rx_tk_q;
    logic [1:0] brk_hi_q;
    logic       rx_par_q;
    logic       rxd_prev_q;
    logic       ovr_q;
    logic       rts_neg_q;
    wire        fall = rxd_prev_q && !rxd;
    wire [3:0]  mid = i_rx_x16 ? 4'(DUC_START_MID16) : 4'h0;
    wire        rx_bit = i_rx_tick && (rx_tk_q == ticks_per_bit);
    wire        rx_midpt = i_rx_tick && (rx_tk_q == mid);
    wire [7:0]  bit_mask = 8'(({1'b0, 8'hFF} >> (4'h8 - nbits)));
    wire [7:0]  rx_word = rx_sh_q >> (4'h8 - nbits);
    wire        start_ok = rx_midpt && !rxd && (rx_st_q == RX_START);

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || rx_reset || !i_rx_en)
        begin
            rx_st_q  <= RX_HUNT;
            rx_sh_q  <= 8'h00;
            rx_cnt_q <= 4'h0;
            rx_tk_q  <= 4'h0;
            rx_par_q <= 1'b0;
            brk_hi_q <= 2'h0;
        end
        else
        begin
            rx_tk_q <= i_rx_tick ? rx_tk_q + 4'h1 : rx_tk_q;
            unique case (rx_st_q)
                RX_HUNT:
                    if (fall)
                    begin
                        rx_st_q <= RX_START;
                        rx_tk_q <= 4'h0;
                    end
                RX_START:
                    if (rx_midpt)
                    begin
                        rx_st_q  <= rxd ? RX_HUNT : RX_DATA;
                        rx_tk_q  <= 4'h0;
                        rx_cnt_q <= 4'h0;
                        rx_par_q <= i_fmt.par_odd;
                    end
                RX_DATA:
                    if (rx_bit)
                    begin
                        rx_tk_q  <= 4'h0;
                        rx_sh_q  <= {rxd, rx_sh_q[7:1]};
                        rx_par_q <= rx_par_q ^ rxd;
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                        if (rx_cnt_q == nbits - 4'h1)
                            rx_st_q <= i_fmt.par_en ? RX_PAR : RX_STOP;
                    end
                RX_PAR:
                    if (rx_bit)
                    begin
                        rx_tk_q  <= 4'h0;
                        rx_par_q <= rx_par_q ^ rxd;
                        rx_st_q  <= RX_STOP;
                    end
                RX_STOP:
                    if (rx_bit)
                    begin
                        rx_tk_q <= 4'h0;
                        if (rxd)
                            rx_st_q <= RX_HUNT;
                        else if ((rx_word & bit_mask) == 8'h00)
                            rx_st_q <= RX_BREAK;
                        else
                            rx_st_q <= RX_REFRAME;
                    end
                RX_REFRAME:
                    if (rxd)
                        rx_st_q <= RX_HUNT;
                    else if (i_rx_tick && rx_tk_q == mid)
                    begin
                        rx_st_q <= RX_START;
                        rx_tk_q <= 4'h0;
                    end
                RX_BREAK:
                begin
                    if (!rxd)
                        brk_hi_q <= 2'h0;
                    else if (i_xtal_edge)
                        brk_hi_q <= brk_hi_q + 2'h1;
                    if (rxd && i_xtal_edge
                        && brk_hi_q == 2'(DUC_BRK_HIGH - 1))
                    begin
                        rx_st_q  <= RX_HUNT;
                        brk_hi_q <= 2'h0;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Character hand-off, overrun, flow control
    // ------------------------------------------------------------
    wire rx_done = (rx_st_q == RX_STOP) && rx_bit && i_rx_en
                   && !rx_reset;
    wire rx_is_brk = !rxd && ((rx_word & bit_mask) == 8'h00);

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || rx_reset)
        begin
            rx_hold_q <= 1'b0;
            rx_new_q  <= '0;
            ovr_q     <= 1'b0;
            rts_neg_q <= 1'b0;
            rxd_prev_q <= 1'b1;
        end
        else
        begin
            rxd_prev_q <= rxd;
            if (rx_done)
            begin
                rx_hold_q     <= 1'b1;
                rx_new_q.data <= rx_is_brk ? 8'h00 : rx_word;
                rx_new_q.brk  <= rx_is_brk;
                rx_new_q.ferr <= !rxd;
                rx_new_q.perr <= i_fmt.par_en && rx_par_q;
            end
            else if (rx_load)
                rx_hold_q <= 1'b0;
            if (start_ok && rx_hold_q && !rx_load)
                ovr_q <= 1'b1;
            else if (i_cmd == DUC_CMD_ERR_RESET)
                ovr_q <= 1'b0;
            if (start_ok && rxf_full && i_rx_flow_en)
                rts_neg_q <= 1'b1;
            else if (!rxf_full)
                rts_neg_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Status presentation and watchdog
    // ------------------------------------------------------------
    logic [2:0] blk_q;
    logic [5:0] wd_bits_q;
    logic [3:0] wd_tk_q;
    wire [2:0] head_st = rxf_valid ?
               {rxf_head.brk, rxf_head.ferr, rxf_head.perr} : 3'h0;
    wire [2:0] stat3 = i_block_err ? (blk_q | head_st) : head_st;
    wire       wd_restart = rx_load || rx_pop;

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || rx_reset)
        begin
            blk_q               <= 3'h0;
            wd_bits_q           <= 6'h00;
            wd_tk_q             <= 4'h0;
            o_wdog_expired      <= 1'b0;
            o_rx_data           <= 8'h00;
            o_rx_stat           <= '0;
            o_rx_ready_flag     <= 1'b0;
            o_rx_fifo_full_flag <= 1'b0;
            o_request_to_send_low <= 1'b0;
        end
        else
        begin
            if (i_cmd == DUC_CMD_ERR_RESET)
                blk_q <= 3'h0;
            else
                blk_q <= blk_q | head_st;
            if (wd_restart || !i_wdog_en || !rxf_valid)
            begin
                wd_bits_q      <= 6'h00;
                wd_tk_q        <= 4'h0;
                o_wdog_expired <= 1'b0;
            end
            else if (i_rx_tick && !o_wdog_expired)
            begin
                wd_tk_q <= (wd_tk_q == ticks_per_bit) ? 4'h0
                                                      : wd_tk_q + 4'h1;
                if (wd_tk_q == ticks_per_bit)
                begin
                    wd_bits_q <= wd_bits_q + 6'h01;
                    if (wd_bits_q == 6'(DUC_WDOG_BITS - 1))
                        o_wdog_expired <= 1'b1;
                end
            end
            o_rx_data           <= rxf_head.data;
            o_rx_stat           <= {stat3, ovr_q};
            o_rx_ready_flag     <= rxf_valid;
            o_rx_fifo_full_flag <= rxf_full;
            if (i_mode_register_two[DUC_MR2_RTS_BIT])
                o_request_to_send_low <= !tx_busy_q;
            else
                o_request_to_send_low <= rts_neg_q;
        end
    end
endmodule

// [core/duc_fifo.sv]
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; flush empties it in one cycle.
 */
`timescale 1ns/1ps
module duc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_flush,
    input  wire logic             i_half,
    // Fill side
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    // Drain side
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic [WIDTH-1:0]      o_data,
    output logic                  o_full
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
            $error("duc_fifo: DEPTH must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    wire  [AW:0]      lim = i_half ? (AW+1)'(DEPTH / 2) : (AW+1)'(DEPTH);
    wire              push = i_valid && o_ready;
    wire              pop  = o_valid && i_ready;

    assign o_full  = (cnt_q >= lim);
    assign o_ready = !o_full;
    assign o_valid = (cnt_q != '0);
    assign o_data  = mem[rd_q];

    always_ff @(posedge i_clk)
    begin
        if (push)
            mem[wr_q] <= i_data;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || i_flush)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q  <= push ? wr_q + 1'b1 : wr_q;
            rd_q  <= pop ? rd_q + 1'b1 : rd_q;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// [core/duc_pkg.sv]
/*
 * Shared constants and carrier types for one serial channel's
 * transmit/receive engine.
 * Assumes a single 25 MHz system clock; baud ticks arrive as
 * same-domain one-cycle pulses.
 */
package duc_pkg;

    // ------------------------------------------------------------
    // Timing and sizes
    // ------------------------------------------------------------
    localparam int          DUC_CLK_HZ      = 25000000;
    localparam int          DUC_START_MID16 = 7;
    localparam int          DUC_WDOG_BITS   = 64;
    localparam int          DUC_BRK_HIGH    = 2;
    localparam int          DUC_DEPTH_SMALL = 8;
    localparam int          DUC_DEPTH_LARGE = 16;
    localparam int          DUC_MR2_CTS_BIT = 4;
    localparam int          DUC_MR2_RTS_BIT = 5;
    localparam int          DUC_SR_OVR_BIT  = 4;
    localparam logic [7:0]  DUC_MR2_RESET   = 8'h00;

    // ------------------------------------------------------------
    // Commands
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DUC_CMD_NONE,
        DUC_CMD_RX_RESET,
        DUC_CMD_TX_RESET,
        DUC_CMD_ERR_RESET,
        DUC_CMD_BRK_START,
        DUC_CMD_BRK_STOP
    } duc_cmd_t;

    // ------------------------------------------------------------
    // Receive FIFO entry: data plus three status bits
    // ------------------------------------------------------------
    typedef struct packed {
        logic       brk;
        logic       ferr;
        logic       perr;
        logic [7:0] data;
    } duc_rx_entry_t;

    // Line format
    typedef struct packed {
        logic [1:0] bits_sel;
        logic       par_en;
        logic       par_odd;
        logic       two_stop;
    } duc_fmt_t;

    // Receive status view
    typedef struct packed {
        logic brk;
        logic ferr;
        logic perr;
        logic ovr;
    } duc_rx_stat_t;

endpackage

// [verif/duc_channel_asserts.sv]
/* Port-level checks on the channel engine.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module duc_channel_asserts (
    input wire logic                  i_clk,
    input wire logic                  i_rstn,
    input wire logic                  i_tx_en,
    input wire logic                  i_tx_wr,
    input wire logic                  i_rx_rd,
    input wire logic                  i_cts_low,
    input wire duc_pkg::duc_cmd_t     i_cmd,
    input wire logic [7:0]            i_mode_register_two,
    input wire logic [7:0]            o_rx_data,
    input wire duc_pkg::duc_rx_stat_t o_rx_stat,
    input wire logic                  o_tx_ready_flag,
    input wire logic                  o_tx_empty_flag,
    input wire logic                  o_tx_irq,
    input wire logic                  o_rx_ready_flag,
    input wire logic                  o_rx_fifo_full_flag,
    input wire logic                  o_txd
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic      brk_q;
    wire logic gate = i_mode_register_two[4] && i_cts_low;
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn || i_cmd == duc_pkg::DUC_CMD_BRK_STOP ||
            i_cmd == duc_pkg::DUC_CMD_TX_RESET)
            brk_q <= 1'b0;
        else if (i_cmd == duc_pkg::DUC_CMD_BRK_START)
            brk_q <= 1'b1;
    end
    // Gate held long enough to pass the pin synchroniser
    sequence s_blocked;
        gate [*3] ##1 (gate && o_tx_empty_flag) ##1 gate [*4];
    endsequence
    sequence s_head_idle;
        (o_rx_ready_flag && !i_rx_rd && i_cmd == duc_pkg::DUC_CMD_NONE) [*4];
    endsequence
    AST_TX_LOAD: assert property (
        i_tx_wr && i_tx_en && o_tx_ready_flag |-> ##[1:3] !o_tx_empty_flag)
        else $error("tx empty not cleared");
    AST_IRQ_OFF: assert property (!i_tx_en [*2] |-> !o_tx_irq)
        else $error("tx irq while disabled");
    AST_TX_RST: assert property (
        i_cmd == duc_pkg::DUC_CMD_TX_RESET |-> ##2 o_txd)
        else $error("line not idle after tx reset");
    AST_BRK: assert property (brk_q && $past(brk_q, 3) |-> !o_txd)
        else $error("break not held low");
    AST_CTS: assert property (s_blocked |=> o_txd)
        else $error("sent while clear-to-send high");
    AST_FULL: assert property (o_rx_fifo_full_flag |-> o_rx_ready_flag)
        else $error("full without ready");
    AST_HEAD: assert property (s_head_idle |-> $stable(o_rx_data))
        else $error("head moved without read");
    AST_RX_RST: assert property (
        i_cmd == duc_pkg::DUC_CMD_RX_RESET |-> ##2
        !(o_rx_ready_flag || o_rx_stat.brk))
        else $error("rx state kept after reset");
endmodule
bind duc_channel duc_channel_asserts chk_u (.i_clk, .i_rstn, .i_tx_en,
    .i_tx_wr, .i_rx_rd, .i_cts_low, .i_cmd, .i_mode_register_two,
    .o_rx_data, .o_rx_stat, .o_tx_ready_flag, .o_tx_empty_flag, .o_tx_irq,
    .o_rx_ready_flag, .o_rx_fifo_full_flag, .o_txd);

// [verif/duc_line_model.sv]
/* Remote sender on the receive line of the channel.
   Assumes 1x bit ticks shared with the channel under test. */
`timescale 1ns/1ps
module duc_line_model (
    input  wire logic i_clk,
    input  wire logic i_tick,
    output logic      o_rxd
);
    initial o_rxd = 1'b1;
    // Start low, data LSB first, one stop, then a mark bit
    task automatic send(input logic [7:0] d, input int n, input logic stp);
        for (int i = 0; i < n + 3; i++)
        begin
            @(posedge i_clk iff i_tick);
            #1 o_rxd = (i == 0) ? 1'b0 : (i <= n) ? d[i-1] :
                       (i == n + 1) ? stp : 1'b1;
        end
    endtask
endmodule

// [verif/tb_duart_channel_tx_rx.sv]
/* Bench: line model on the receive pin, frame capture on transmit.
   Assumes 1x bit ticks every 4 clocks, FIFOs at 8 deep. */
`timescale 1ns/1ps
module tb_duart_channel_tx_rx;
    logic i_clk = 1'b0, i_rstn = 1'b0, i_tx_en = 1'b0, i_rx_en = 1'b0;
    logic i_tx_wr = 1'b0, i_rx_rd = 1'b0, i_cts_low = 1'b0, tick = 1'b0;
    logic [1:0] tcnt = 2'h0;
    logic [7:0] i_tx_data = 8'h00, mr2 = 8'h00, got, rx_data;
    logic txd, rxd, trdy, temp, rrdy, full;
    duc_pkg::duc_cmd_t cmd = duc_pkg::DUC_CMD_NONE;
    duc_pkg::duc_fmt_t fmt = 5'h18;
    duc_pkg::duc_rx_stat_t stat;
    int error_cnt = 0, check_count = 0;
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        tcnt <= tcnt + 2'h1;
        tick <= (tcnt == 2'h3);
    end
    duc_line_model line_u (.i_clk(i_clk), .i_tick(tick), .o_rxd(rxd));
    duc_channel dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_tx_tick(tick),
        .i_rx_tick(tick), .i_rx_x16(1'b0), .i_xtal_edge(tick),
        .i_tx_en(i_tx_en), .i_rx_en(i_rx_en), .i_cmd(cmd),
        .i_mode_register_two(mr2), .i_fmt(fmt), .i_block_err(1'b0),
        .i_rx_flow_en(1'b0), .i_depth8(1'b1), .i_wdog_en(1'b0),
        .i_tx_wr(i_tx_wr), .i_tx_data(i_tx_data), .i_rx_rd(i_rx_rd),
        .o_rx_data(rx_data), .o_rx_stat(stat), .o_tx_ready_flag(trdy),
        .o_tx_empty_flag(temp), .o_tx_irq(), .o_rx_ready_flag(rrdy),
        .o_rx_fifo_full_flag(full), .o_wdog_expired(), .i_rxd(rxd),
        .i_cts_low(i_cts_low), .o_txd(txd), .o_request_to_send_low());
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic go(input duc_pkg::duc_cmd_t c);
        cmd = c;
        step(1);
        cmd = duc_pkg::DUC_CMD_NONE;
        step(2);
    endtask
    // Bounded waits; a stuck line ends as a mismatch
    task automatic get_tx(output logic [7:0] d);
        for (int k = 0; k < 400 && txd !== 1'b0; k++) step(1);
        step(2);
        for (int i = 0; i < 8; i++)
        begin
            step(4);
            d[i] = txd;
        end
        step(4);
        chk({7'h00, txd}, 8'h01);
    endtask
    task automatic finish_test;
        if (error_cnt == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        #100000;
        error_cnt++;
        finish_test;
    end
    initial
    begin
        step(3);
        i_rstn = 1'b1;
        i_tx_en = 1'b1;
        i_rx_en = 1'b1;
        step(3);
        chk({6'h00, trdy, temp}, 8'h03);
        mr2 = 8'h10;
        i_cts_low = 1'b1;
        step(4);
        i_tx_data = 8'hA5;
        i_tx_wr = 1'b1;
        step(1);
        i_tx_wr = 1'b0;
        step(40);
        chk({6'h00, temp, txd}, 8'h01);
        i_cts_low = 1'b0;
        get_tx(got);
        chk(got, 8'hA5);
        go(duc_pkg::DUC_CMD_BRK_START);
        step(8);
        chk({7'h00, txd}, 8'h00);
        go(duc_pkg::DUC_CMD_BRK_STOP);
        fmt = 5'h00;
        for (logic [7:0] i = 8'h00; i < 8'h08; i++) line_u.send(8'hF0 + i, 5, 1'b1);
        step(8);
        chk({7'h00, full}, 8'h01);
        for (logic [7:0] i = 8'h00; i < 8'h08; i++)
        begin
            chk(rx_data, 8'h10 + i);
            i_rx_rd = 1'b1;
            step(1);
            i_rx_rd = 1'b0;
            step(2);
        end
        line_u.send(8'h00, 5, 1'b0);
        for (int k = 0; k < 400 && rrdy !== 1'b1; k++) step(1);
        step(3);
        chk({stat.brk, rx_data[6:0]}, 8'h80);
        go(duc_pkg::DUC_CMD_RX_RESET);
        chk({6'h00, rrdy, stat.brk}, 8'h00);
        go(duc_pkg::DUC_CMD_TX_RESET);
        i_tx_en = 1'b0;
        step(4);
        finish_test;
    end
endmodule
